// ### inc/pls_map.svh
// pls_map.svh: offsets, field positions, reset values, speed thresholds
// assumes: included by the supervisor core and the phase_loss_supervisor_bench only
// Function
// RL1: input mode decodes auto/warn/alarm/disabled
// RL2: auto mode raises warning on input loss
// RL3: alarm mode raises error instead of warning
// RL4: input loss flag sits in status bit 10
// RL5: warn/alarm mode sets flag on one-phase open
// RL6: disabled mode keeps loss flag clear
// RL7: policy 0: flag for one phase only; code sets it only while servo on
// RL8: policy 1: flag for one/two/all open; code sets it only while servo on
// RL9: policies 2/3: flag clear while servo off
// RL10: detect motor phase open, raise error
// RL11: suspend output detection on other faults
// RL12: motorless run blocks output detection
// RL13: source 0: measured speed above threshold
// RL14: source 1: commanded speed above threshold
// RL15: no output detection while brake interlock on
// RL16: output detection only for one phase open
// RL17: output enable defaults to disabled
// RL18: source defaults measured; torque+command never fires
// RL19: pressure adaptive+command never fires
// RL20: input loss alarms only during servo on
// RL21: input alarms only for single phase loss
// RL22: sensing inputs synchronous, alarms registered
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH
// register byte offsets
`define PLS_OFS_CTRL      8'h00
`define PLS_OFS_STATUS    8'h04
`define PLS_OFS_CLEAR     8'h08
// control field positions
`define PLS_CTRL_IN_MODE  1:0
`define PLS_CTRL_POLICY   3:2
`define PLS_CTRL_OUT_EN   4
`define PLS_CTRL_SRC      5
`define PLS_CTRL_MLESS    6
`define PLS_CTRL_MOTOR    8:7
`define PLS_CTRL_TORQUE   9
`define PLS_CTRL_PADAPT   10
`define PLS_CTRL_W        11
`define PLS_CTRL_RESET    11'h000
// status field positions
`define PLS_ST_WARN       0
`define PLS_ST_ERR        1
`define PLS_ST_CAUSE_IN   2
`define PLS_ST_CAUSE_OUT  3
`define PLS_ST_FLAG       10
// speed thresholds in r/min or mm/s
`define PLS_THR_ROTARY    16'h0032
`define PLS_THR_LINEAR    16'h0032
`define PLS_THR_DIRECT    16'h0019
`define PLS_RESP_OKAY     2'h0
`define PLS_RESP_SLVERR   2'h2
`endif

// ### inc/pls_pkg.sv
// pls_pkg: mode and selector types for the phase loss supervisor
// assumes: compiled before the core
package pls_pkg;
   typedef enum logic [1:0] {
      PLS_IN_AUTO, PLS_IN_WARN, PLS_IN_ALARM, PLS_IN_OFF
   } pls_in_mode_e;
   typedef enum logic [1:0] {
      PLS_POL_ON_ONE, PLS_POL_ON_ANY, PLS_POL_ONE, PLS_POL_ANY
   } pls_policy_e;
   typedef enum logic [1:0] {
      PLS_MOT_ROTARY, PLS_MOT_LINEAR, PLS_MOT_DIRECT, PLS_MOT_SPARE
   } pls_motor_e;
endpackage : pls_pkg

// ### core/pls_supervisor.sv
// pls_supervisor: input and output phase loss supervision, axi4-lite regs
// assumes: sensing inputs and faults arrive on aclk, already synchronous
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "pls_map.svh"
module pls_supervisor
   import pls_pkg::*;
(
   input  wire logic        aclk,            // 100 MHz control clock
   input  wire logic        aresetn,         // sync reset, active low
   input  wire logic        ce,              // clock enable, freezes all
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output logic             s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write byte enables
   input  wire logic        s_axi_wvalid,    // write data valid
   output logic             s_axi_wready,    // write data ready
   output logic [1:0]       s_axi_bresp,     // write response
   output logic             s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output logic             s_axi_arready,   // read address ready
   output logic [31:0]      s_axi_rdata,     // read data
   output logic [1:0]       s_axi_rresp,     // read response
   output logic             s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   input  wire logic [2:0]  supply_open,     // per supply phase open
   input  wire logic [2:0]  motor_open,      // per motor phase open (u,v,w)
   input  wire logic        servo_on,        // servo-on state
   input  wire logic        brake_interlock, // brake interlock output on
   input  wire logic        other_fault,     // any other alarm or warning
   input  wire logic [15:0] meas_speed,      // measured speed, signed
   input  wire logic [15:0] cmd_speed,       // commanded speed, signed
   output logic             phase_loss_warning, // level warning
   output logic             phase_loss_error,   // sticky error
   output logic             input_loss_flag     // status word bit 10
);

   logic [`PLS_CTRL_W-1:0] ctrl_reg;
   logic        warn_reg;
   logic        err_reg;
   logic        cause_in_reg;
   logic        cause_out_reg;
   logic        flag_reg;
   logic        aw_got_reg;
   logic        w_got_reg;
   logic [7:0]  waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        aw_fire;
   logic        w_fire;
   logic        b_fire;
   logic        ar_fire;
   logic        r_fire;
   logic        wr_do;
   logic        clr_err;

   pls_in_mode_e in_mode;
   pls_policy_e  policy;
   pls_motor_e   motor;
   logic        one_supply;
   logic        any_supply;
   logic        one_motor;
   logic        in_enabled;
   logic        in_warn_next;
   logic        in_err_set;
   logic        flag_next;
   logic [15:0] speed_sel;
   logic [15:0] speed_mag;
   logic [15:0] speed_thr;
   logic        out_blocked;
   logic        out_err_set;
   logic [31:0] status_word;

   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire  = s_axi_wvalid & s_axi_wready;
   assign b_fire  = s_axi_bvalid & s_axi_bready;
   assign ar_fire = s_axi_arvalid & s_axi_arready;
   assign r_fire  = s_axi_rvalid & s_axi_rready;
   assign wr_do   = aw_got_reg & w_got_reg & ~s_axi_bvalid;

   // field views of the control register
   assign in_mode = pls_in_mode_e'(ctrl_reg[`PLS_CTRL_IN_MODE]); // RL1
   assign policy  = pls_policy_e'(ctrl_reg[`PLS_CTRL_POLICY]);
   assign motor   = pls_motor_e'(ctrl_reg[`PLS_CTRL_MOTOR]);

   // exactly-one and any-open decodes of the phase indications
   assign one_supply = (supply_open == 3'h1) | (supply_open == 3'h2) |
                       (supply_open == 3'h4);
   assign any_supply = |supply_open;
   assign one_motor  = (motor_open == 3'h1) | (motor_open == 3'h2) |
                       (motor_open == 3'h4); // RL16

   // input side: auto counts as enabled on this amplifier class
   assign in_enabled = (in_mode != PLS_IN_OFF); // RL1 RL6
   // servo-off and multi-phase loss never alarm
   assign in_warn_next = servo_on & one_supply &
                         ((in_mode == PLS_IN_AUTO) |
                          (in_mode == PLS_IN_WARN)); // RL2 RL20 RL21
   assign in_err_set   = servo_on & one_supply &
                         (in_mode == PLS_IN_ALARM); // RL3 RL20 RL21

   // status flag: policy bit0 picks one-only or any-open, servo-on gated
   always_comb begin
      flag_next = 1'b0;
      if (in_enabled && servo_on) begin // RL6 RL9
         case (policy)
            PLS_POL_ON_ONE: flag_next = one_supply;  // RL7
            PLS_POL_ON_ANY: flag_next = any_supply;  // RL8
            PLS_POL_ONE:    flag_next = one_supply;  // RL9 RL5
            default:        flag_next = any_supply;  // RL9
         endcase
      end
   end

   // output side: pick judgment speed and take its magnitude
   assign speed_sel = ctrl_reg[`PLS_CTRL_SRC] ? cmd_speed
                                               : meas_speed; // RL13 RL14
   assign speed_mag = speed_sel[15] ? 16'(-speed_sel) : speed_sel;

   // threshold depends on motor kind; spare code behaves as rotary
   always_comb begin
      speed_thr = `PLS_THR_ROTARY;
      case (motor)
         PLS_MOT_LINEAR: speed_thr = `PLS_THR_LINEAR;
         PLS_MOT_DIRECT: speed_thr = `PLS_THR_DIRECT;
         default:        speed_thr = `PLS_THR_ROTARY;
      endcase
   end

   // command source is unreliable in torque and pressure-adaptive use,
   // so those combinations never fire rather than false-trip
   assign out_blocked = ctrl_reg[`PLS_CTRL_SRC] &
                        (ctrl_reg[`PLS_CTRL_TORQUE] |
                         ctrl_reg[`PLS_CTRL_PADAPT]); // RL18 RL19

   // own warning counts as another fault for the output detector
   assign out_err_set = ctrl_reg[`PLS_CTRL_OUT_EN] &      // RL17
                        ~ctrl_reg[`PLS_CTRL_MLESS] &      // RL12
                        servo_on &                        // RL13 RL14
                        (speed_mag >= speed_thr) &        // RL13 RL14
                        ~brake_interlock &                // RL15
                        ~other_fault & ~warn_reg &        // RL11
                        ~out_blocked & one_motor;         // RL10 RL16

   // write-one-to-clear request for the sticky error
   assign clr_err = wr_do & (waddr_reg == `PLS_OFS_CLEAR) &
                    wstrb_reg[0] & wdata_reg[0];

   // alarm state registered on the control clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warn_reg      <= 1'b0;
         err_reg       <= 1'b0;
         cause_in_reg  <= 1'b0;
         cause_out_reg <= 1'b0;
         flag_reg      <= 1'b0;
      end else if (ce) begin
         warn_reg <= in_warn_next; // RL2 RL22
         flag_reg <= flag_next;    // RL4
         // a new event in the clear cycle wins over the clear
         if (in_err_set)
            cause_in_reg <= 1'b1; // RL3
         else if (clr_err)
            cause_in_reg <= 1'b0;
         if (out_err_set)
            cause_out_reg <= 1'b1; // RL10
         else if (clr_err)
            cause_out_reg <= 1'b0;
         if (in_err_set || out_err_set)
            err_reg <= 1'b1; // RL22
         else if (clr_err)
            err_reg <= 1'b0;
      end
   end

   assign phase_loss_warning = warn_reg;
   assign phase_loss_error   = err_reg;
   assign input_loss_flag    = flag_reg;

   // control register, byte lanes 0 and 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `PLS_CTRL_RESET; // RL17 RL18
      end else if (ce && wr_do && waddr_reg == `PLS_OFS_CTRL) begin
         if (wstrb_reg[0])
            ctrl_reg[7:0] <= wdata_reg[7:0];
         if (wstrb_reg[1])
            ctrl_reg[`PLS_CTRL_W-1:8] <= wdata_reg[`PLS_CTRL_W-1:8];
      end
   end

   // write channel: address and data accepted in either order,
   // one write under way at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         waddr_reg     <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else if (ce) begin
         if (aw_fire) begin
            aw_got_reg    <= 1'b1;
            waddr_reg     <= {s_axi_awaddr[7:2], 2'h0};
            s_axi_awready <= 1'b0;
         end else begin
            if (wr_do)
               aw_got_reg <= 1'b0;
            if (!aw_got_reg && !s_axi_bvalid)
               s_axi_awready <= 1'b1;
         end
         if (w_fire) begin
            w_got_reg    <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else begin
            if (wr_do)
               w_got_reg <= 1'b0;
            if (!w_got_reg && !s_axi_bvalid)
               s_axi_wready <= 1'b1;
         end
      end
   end

   // write response; status is read-only, unmapped answers slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PLS_RESP_OKAY;
      end else if (ce) begin
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            if (waddr_reg == `PLS_OFS_CTRL || waddr_reg == `PLS_OFS_CLEAR)
               s_axi_bresp <= `PLS_RESP_OKAY;
            else
               s_axi_bresp <= `PLS_RESP_SLVERR;
         end else if (b_fire) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // status word shows the block's own state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`PLS_ST_WARN]      = warn_reg;
      status_word[`PLS_ST_ERR]       = err_reg;
      status_word[`PLS_ST_CAUSE_IN]  = cause_in_reg;
      status_word[`PLS_ST_CAUSE_OUT] = cause_out_reg;
      status_word[`PLS_ST_FLAG]      = flag_reg; // RL4
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PLS_RESP_OKAY;
      end else if (ce) begin
         if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PLS_RESP_OKAY;
            // compare full byte addresses so both sides are 8 bits wide
            if ({s_axi_araddr[7:2], 2'h0} == `PLS_OFS_CTRL) begin
               s_axi_rdata <= {21'h000000, ctrl_reg};
            end else if ({s_axi_araddr[7:2], 2'h0} == `PLS_OFS_STATUS) begin
               s_axi_rdata <= status_word;
            end else if ({s_axi_araddr[7:2], 2'h0} == `PLS_OFS_CLEAR) begin
               s_axi_rdata <= 32'h0000_0000;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `PLS_RESP_SLVERR;
            end
         end else begin
            if (r_fire)
               s_axi_rvalid <= 1'b0;
            if (!s_axi_rvalid && !s_axi_arready)
               s_axi_arready <= 1'b1;
         end
      end
   end

   // checks: each but a_default_off ties an output or cause_out_reg one enabled cycle after its cause
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_auto_warns: assert property (ce && servo_on && one_supply && // RL2
      in_mode == PLS_IN_AUTO |=> phase_loss_warning)
      else $error("auto mode did not warn on one-phase loss");
   a_alarm_errs: assert property (ce && servo_on && one_supply && // RL3
      in_mode == PLS_IN_ALARM |=> phase_loss_error && !phase_loss_warning)
      else $error("alarm mode did not raise error alone");
   a_flag_off_disabled: assert property (ce && in_mode == PLS_IN_OFF // RL6
      |=> !input_loss_flag)
      else $error("loss flag set while input detection disabled");
   a_flag_servo_off: assert property (ce && !servo_on // RL9 RL20
      |=> !input_loss_flag && !phase_loss_warning)
      else $error("flag or warning while servo off");
   a_flag_multi: assert property (ce && in_enabled && servo_on && // RL7
      supply_open == 3'h7 |=> input_loss_flag == policy[0])
      else $error("multi-phase flag disagrees with policy");
   a_flag_one: assert property (ce && in_enabled && servo_on && // RL5
      one_supply |=> input_loss_flag)
      else $error("one-phase loss not flagged");
   // output detection may still raise the error with no supply loss
   a_no_multi_alarm: assert property (ce && !one_supply && !clr_err && // RL21
      !out_err_set |=> phase_loss_error == $past(phase_loss_error)
          && !phase_loss_warning)
      else $error("alarm state moved without single supply loss");
   a_brake_blocks: assert property (ce && brake_interlock && // RL15
      !in_err_set && !cause_out_reg |=> !cause_out_reg)
      else $error("output loss raised under brake interlock");
   a_fault_blocks: assert property (ce && other_fault && // RL11
      !cause_out_reg |=> !cause_out_reg)
      else $error("output loss raised during another fault");
   a_servo_off_out: assert property (ce && !servo_on && // RL13 RL14
      !cause_out_reg |=> !cause_out_reg)
      else $error("output loss raised while servo off");
   a_cmd_blocked: assert property (ce && out_blocked && // RL18 RL19
      !cause_out_reg |=> !cause_out_reg)
      else $error("output loss raised with command source blocked");
   a_out_detect: assert property (ce && out_err_set // RL10
      |=> phase_loss_error && cause_out_reg)
      else $error("output phase loss not raised");
   a_default_off: assert property ($rose(aresetn) // RL17
      |-> !ctrl_reg[`PLS_CTRL_OUT_EN] && !ctrl_reg[`PLS_CTRL_SRC])
      else $error("output detection not off after reset");
   a_wr_resp: assert property (ce && wr_do |=> s_axi_bvalid)
      else $error("write response missing");

   c_input_warn:  cover property (ce && in_warn_next ##1 phase_loss_warning);
   c_output_err:  cover property (ce && out_err_set ##1 cause_out_reg);
   c_clear_error: cover property (err_reg ##1 !err_reg);
   c_flag_multi:  cover property (input_loss_flag && supply_open == 3'h7);
   c_input_err:   cover property (ce && in_err_set ##1 cause_in_reg);

endmodule : pls_supervisor
`default_nettype wire

// ### dv/pls_host_model.sv
// pls_host_model: axi4-lite master standing in for the host controller
// assumes: one clock; tasks are entered just after a rising edge of aclk
`timescale 1ns/100ps
`default_nettype none
module pls_host_model (
   input  wire logic        aclk,    // control clock
   output logic [7:0]       awaddr,  // write address
   output logic             awvalid, // write address valid
   input  wire logic        awready, // write address ready
   output logic [31:0]      wdata,   // write data
   output logic             wvalid,  // write data valid
   input  wire logic        wready,  // write data ready
   input  wire logic [1:0]  bresp,   // write response
   input  wire logic        bvalid,  // write response valid
   output logic             bready,  // write response ready
   output logic [7:0]       araddr,  // read address
   output logic             arvalid, // read address valid
   input  wire logic        arready, // read address ready
   input  wire logic [31:0] rdata,   // read data
   input  wire logic [1:0]  rresp,   // read response
   input  wire logic        rvalid,  // read data valid
   output logic             rready   // read data ready
);
   // idle bus from time zero
   initial begin
      awaddr = 8'h00;
      awvalid = 1'h0;
      wdata = 32'h0;
      wvalid = 1'h0;
      bready = 1'h0;
      araddr = 8'h00;
      arvalid = 1'h0;
      rready = 1'h0;
   end

   // released payloads are inverted so a late sample cannot pass by luck
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] resp);
      logic done;
      done = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'h0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'h0;
            wdata <= ~d;
         end
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'h0;
            done = 1'h1;
         end
      end
      // let an edge pass so a following call never re-raises bready
      @(posedge aclk);
   endtask : wr

   // read: address held until taken, rready held until the data arrive
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      logic done;
      done = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) begin
            arvalid <= 1'h0;
            araddr <= ~a;
         end
         if (rvalid && rready) begin
            d = rdata;
            resp = rresp;
            rready <= 1'h0;
            done = 1'h1;
         end
      end
      // let an edge pass so a following call never re-raises rready
      @(posedge aclk);
   endtask : rd
endmodule : pls_host_model
`default_nettype wire

// ### dv/phase_loss_supervisor_bench.sv
// phase_loss_supervisor_bench: register and supervision tests
// assumes: pls_host_model drives the bus; sensing driven here on aclk
`timescale 1ns/100ps
`default_nettype none
`include "pls_map.svh"
module phase_loss_supervisor_bench;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, servo_on;
   logic        brake_interlock, other_fault, warn, err, flag;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [2:0]  supply_open, motor_open;
   logic [15:0] meas_speed, cmd_speed;
   int          err_count, cmp_count, cyc;
   localparam logic [1:0]  OK = `PLS_RESP_OKAY;
   localparam logic [15:0] R = `PLS_THR_ROTARY;
   localparam logic [15:0] D = `PLS_THR_DIRECT;

   pls_supervisor DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .supply_open(supply_open),
      .motor_open(motor_open), .servo_on(servo_on),
      .brake_interlock(brake_interlock), .other_fault(other_fault),
      .meas_speed(meas_speed), .cmd_speed(cmd_speed),
      .phase_loss_warning(warn), .phase_loss_error(err),
      .input_loss_flag(flag));
   pls_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   // free-running 100 MHz clock
   always #5 aclk = ~aclk;

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic [1:0] r;
      host.wr(a, d, r);
      cmp({30'h0, r}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host.rd(a, d, r);
      cmp(d, ed);
      cmp({30'h0, r}, {30'h0, er});
   endtask : rd

   // input loss case; e is {flag, error, warning}, error cleared after
   task automatic in_case(input logic [10:0] c, input logic [2:0] so,
                          input logic son, input logic [2:0] e);
      wr(`PLS_OFS_CTRL, {21'h0, c}, OK);
      supply_open <= so;
      servo_on <= son;
      repeat (3) @(posedge aclk);
      cmp({29'h0, flag, err, warn}, {29'h0, e});
      rd(`PLS_OFS_STATUS, {21'h0, e[2], 7'h0, e[1], e[1], e[0]}, OK);
      supply_open <= 3'h0;
      servo_on <= 1'h0;
      wr(`PLS_OFS_CLEAR, 32'h1, OK);
      rd(`PLS_OFS_STATUS, 32'h0, OK);
   endtask : in_case

   // output loss case; cause is removed first to prove the error sticks
   task automatic out_case(input logic [10:0] c, input logic [2:0] mo,
      input logic son, input logic brk, input logic flt,
      input logic [15:0] ms, input logic [15:0] cs, input logic hit);
      wr(`PLS_OFS_CTRL, {21'h0, c}, OK);
      motor_open <= mo;
      servo_on <= son;
      brake_interlock <= brk;
      other_fault <= flt;
      meas_speed <= ms;
      cmd_speed <= cs;
      repeat (3) @(posedge aclk);
      motor_open <= 3'h0;
      servo_on <= 1'h0;
      repeat (2) @(posedge aclk);
      cmp({31'h0, err}, {31'h0, hit});
      rd(`PLS_OFS_STATUS, hit ? 32'h0000_000a : 32'h0, OK);
      wr(`PLS_OFS_CLEAR, 32'h1, OK);
      rd(`PLS_OFS_STATUS, 32'h0, OK);
   endtask : out_case

   // main sequence
   initial begin
      aclk = 1'h0;
      aresetn = 1'h0;
      {supply_open, motor_open} = 6'h00;
      {servo_on, brake_interlock, other_fault} = 3'h0;
      {meas_speed, cmd_speed} = 32'h0;
      {err_count, cmp_count, cyc} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      rd(`PLS_OFS_CTRL, 32'h0, OK);
      rd(`PLS_OFS_STATUS, 32'h0, OK);
      wr(`PLS_OFS_CTRL, 32'hffff_ffff, OK);
      rd(`PLS_OFS_CTRL, 32'h0000_07ff, OK);
      wr(`PLS_OFS_STATUS, 32'h1, `PLS_RESP_SLVERR);
      rd(8'h0c, 32'h0, `PLS_RESP_SLVERR);
      in_case(11'h000, 3'h1, 1'h1, 3'h5);
      in_case(11'h001, 3'h1, 1'h1, 3'h5);
      in_case(11'h002, 3'h1, 1'h1, 3'h6);
      in_case(11'h003, 3'h1, 1'h1, 3'h0);
      in_case(11'h001, 3'h3, 1'h1, 3'h0);
      in_case(11'h002, 3'h7, 1'h1, 3'h0);
      in_case(11'h005, 3'h3, 1'h1, 3'h4);
      in_case(11'h005, 3'h7, 1'h1, 3'h4);
      in_case(11'h009, 3'h1, 1'h0, 3'h0);
      in_case(11'h00e, 3'h1, 1'h0, 3'h0);
      in_case(11'h00a, 3'h1, 1'h1, 3'h6);
      in_case(11'h00d, 3'h3, 1'h1, 3'h4);
      out_case(11'h010, 3'h1, 1, 0, 0, R, 0, 1);
      out_case(11'h010, 3'h1, 1, 0, 0, R - 16'h1, 0, 0);
      out_case(11'h010, 3'h1, 0, 0, 0, R, 0, 0);
      out_case(11'h010, 3'h4, 1, 0, 0, 16'h0 - R, 0, 1);
      out_case(11'h000, 3'h1, 1, 0, 0, R, 0, 0);
      out_case(11'h010, 3'h2, 1, 1, 0, R, 0, 0);
      out_case(11'h010, 3'h1, 1, 0, 1, R, 0, 0);
      out_case(11'h050, 3'h1, 1, 0, 0, R, 0, 0);
      out_case(11'h010, 3'h3, 1, 0, 0, R, 0, 0);
      out_case(11'h030, 3'h1, 1, 0, 0, 0, R, 1);
      out_case(11'h030, 3'h1, 1, 0, 0, R, R - 16'h1, 0);
      out_case(11'h230, 3'h1, 1, 0, 0, R, R, 0);
      out_case(11'h210, 3'h1, 1, 0, 0, R, 0, 1);
      out_case(11'h430, 3'h1, 1, 0, 0, R, R, 0);
      out_case(11'h110, 3'h1, 1, 0, 0, D, 0, 1);
      out_case(11'h110, 3'h1, 1, 0, 0, D - 16'h1, 0, 0);
      out_case(11'h090, 3'h1, 1, 0, 0, `PLS_THR_LINEAR, 0, 1);
      report_and_stop();
   end
endmodule : phase_loss_supervisor_bench
`default_nettype wire
